/* logic/cps_pkg.sv */
package cps_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int PC_W = 14;
  localparam int DATA_W = 8;
  localparam int RAM_DEPTH = 256;
  localparam int ROM_TEST_BYTES = 32;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [13:0] PC_RESET = 14'h0000;
  localparam logic [7:0] PSTK_RESET = 8'h00;
  localparam logic [7:0] DSP_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Program memory map
  // ----------------------------------------------------------------
  localparam logic [13:0] VEC_BUS_RESET = 14'h0002;
  localparam logic [13:0] VEC_TMR_128US = 14'h0004;
  localparam logic [13:0] VEC_TMR_1MS = 14'h0006;
  localparam logic [13:0] VEC_EP0 = 14'h0008;
  localparam logic [13:0] VEC_RESERVED = 14'h0012;
  localparam logic [13:0] VEC_DAC = 14'h0014;
  localparam logic [13:0] VEC_GPIO = 14'h0016;
  localparam logic [13:0] VEC_I2C = 14'h0018;
  localparam logic [13:0] USER_CODE_START = 14'h001A;
  localparam logic [13:0] USER_ROM_END = 14'h1FDF;

  // ----------------------------------------------------------------
  // Commands and interrupt sources
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    CMD_NOP, CMD_PAGE, CMD_JUMP, CMD_CALL, CMD_INT_ACK, CMD_SUB_RET, CMD_INT_RET,
    CMD_LOAD_PSTK, CMD_EI, CMD_DI, CMD_PUSH, CMD_POP, CMD_SWAP_DSP,
    CMD_LOAD_IMM, CMD_LOAD_DIR, CMD_LOAD_IDX, CMD_STORE_DIR, CMD_STORE_IDX
  } cps_cmd_t;

  typedef enum logic [3:0] {
    SRC_BUS_RESET, SRC_TMR_128US, SRC_TMR_1MS, SRC_EP0, SRC_EP1, SRC_EP2,
    SRC_EP3, SRC_EP4, SRC_DAC, SRC_GPIO, SRC_I2C
  } cps_src_t;

  function automatic logic [13:0] cps_vector(input cps_src_t src);
    logic [3:0] ep_index;
    ep_index = 4'(src) - 4'(SRC_EP0);
    case (src)
      SRC_BUS_RESET: cps_vector = VEC_BUS_RESET;
      SRC_TMR_128US: cps_vector = VEC_TMR_128US;
      SRC_TMR_1MS: cps_vector = VEC_TMR_1MS;
      SRC_EP0, SRC_EP1, SRC_EP2, SRC_EP3, SRC_EP4: cps_vector = VEC_EP0 + {9'h000, ep_index, 1'b0};
      SRC_DAC: cps_vector = VEC_DAC;
      SRC_GPIO: cps_vector = VEC_GPIO;
      SRC_I2C: cps_vector = VEC_I2C;
      default: cps_vector = VEC_RESERVED;
    endcase
  endfunction

endpackage

/* logic/cps_mem_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cps_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface // cps_mem_if
`default_nettype wire

/* logic/cps_data_ram.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_data_ram
  import cps_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH
)(
  input wire logic sys_clk,
  cps_mem_if.mem bus
);

  // ----------------------------------------------------------------
  // Storage, one flip-flop byte per entry
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] cell_reg [DEPTH];

  for (genvar i = 0; i < DEPTH; i++) begin : g_cell
    always_ff @(posedge sys_clk) begin
      if (bus.we && (bus.addr == 8'(i))) begin
        cell_reg[i] <= bus.wdata;
      end
    end
  end

  assign bus.rdata = cell_reg[bus.addr];

endmodule // cps_data_ram
`default_nettype wire

/* logic/cps_core.sv */
// Overview of operation
// - Fourteen-bit counter cleared to zero at reset
// - Sequential steps wrap low byte; page advances upper
// - Interrupt and call save counter, flags as two bytes
// - Interrupt return restores flags; plain return does not
// - User program memory ends at 0x1FDF
// - Fixed even vectors for non-endpoint interrupt sources
// - Endpoints zero to four vector 0x0008 to 0x0010
// - Program stack pointer resets zero, grows upward
// - Stack pointer write-only by load; counter hidden
// - Acknowledge disables interrupts, writes byte, increments twice
// - Interrupt return decrements, restores second then first, then enables
// - Call pushes counter and flags, pointer plus two
// - Return reloads counter, keeps flags, pointer minus two
// - 256 bytes data RAM with 8-bit addresses
// - Push pre-decrements data pointer then writes
// - Pop reads then post-increments data pointer
// - Data pointer resets zero; push wraps to 0xFF
// - Swap exchanges accumulator and data stack pointer
// - Immediate operand is the second instruction byte
// - Direct operand byte is the RAM address
// - Indexed address is constant plus index register
// - Saved stack bytes stay ordinary readable RAM
`timescale 1ns/1ps
`default_nettype none
module cps_core
  import cps_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic cmd_valid,
  input wire cps_cmd_t cmd_code,
  input wire logic [7:0] cmd_operand,
  input wire logic [13:0] cmd_target,
  input wire cps_src_t int_source,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] index_in,
  input wire logic flag_we,
  input wire logic carry_in,
  input wire logic zero_in,
  output logic cmd_ready,
  output logic [13:0] pc,
  output logic carry_flag,
  output logic zero_flag,
  output logic int_enable,
  output logic [7:0] read_data,
  output logic read_valid,
  output logic [7:0] swap_data,
  output logic user_rom_over
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_SAVE2, ST_REST_HI, ST_REST_LO} cps_state_t;

  cps_state_t state_reg, state_next;
  logic [13:0] pc_reg, pc_next;
  logic [7:0] pstk_reg, pstk_next;
  logic [7:0] dsp_reg, dsp_next;
  logic ie_reg, ie_next;
  logic carry_reg, carry_next;
  logic zero_reg, zero_next;
  logic [7:0] save_hi_reg, save_hi_next;
  logic [13:0] dest_reg, dest_next;
  logic [7:0] hold_reg, hold_next;
  logic iret_reg, iret_next;
  logic ready_reg, ready_next;
  logic [7:0] rd_reg, rd_next;
  logic rd_valid_reg, rd_valid_next;
  logic [7:0] swap_reg, swap_next;
  logic rom_over_reg;

  cps_mem_if #(.AW(8), .DW(DATA_W)) mem_bus ();

  cps_data_ram #(.DEPTH(RAM_DEPTH)) u_ram (
    .sys_clk(sys_clk),
    .bus(mem_bus)
  );

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire logic take;
  wire logic is_save;
  wire logic is_store;
  wire logic [13:0] pc_step1;
  wire logic [13:0] pc_step2;
  wire logic [13:0] pc_page;
  wire logic [13:0] save_pc;
  wire logic [7:0] dsp_dec;
  wire logic [7:0] idx_addr;
  wire logic [7:0] data_addr;

  assign take = cmd_valid && ready_reg;
  assign is_save = (cmd_code == CMD_CALL) || (cmd_code == CMD_INT_ACK);
  assign is_store = (cmd_code == CMD_STORE_DIR) || (cmd_code == CMD_STORE_IDX);
  assign pc_step1 = {pc_reg[13:8], pc_reg[7:0] + 8'h01};
  assign pc_step2 = {pc_reg[13:8], pc_reg[7:0] + 8'h02};
  assign pc_page = {pc_reg[13:8] + 6'h01, pc_reg[7:0] + 8'h01};
  assign save_pc = (cmd_code == CMD_CALL) ? pc_step2 : pc_reg;
  assign dsp_dec = dsp_reg - 8'h01;
  assign idx_addr = cmd_operand + index_in;

  // ----------------------------------------------------------------
  // Data RAM port
  // ----------------------------------------------------------------
  assign data_addr =
    (state_reg != ST_IDLE) ? pstk_reg :
    is_save ? pstk_reg :
    (cmd_code == CMD_PUSH) ? dsp_dec :
    (cmd_code == CMD_POP) ? dsp_reg :
    ((cmd_code == CMD_LOAD_IDX) || (cmd_code == CMD_STORE_IDX)) ? idx_addr :
    cmd_operand;
  assign mem_bus.addr = data_addr;
  assign mem_bus.we = (state_reg == ST_SAVE2) ||
    (take && (is_save || is_store || (cmd_code == CMD_PUSH)));
  assign mem_bus.wdata =
    (state_reg == ST_SAVE2) ? save_hi_reg :
    is_save ? save_pc[7:0] :
    acc_in;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    pstk_next = pstk_reg;
    dsp_next = dsp_reg;
    ie_next = ie_reg;
    carry_next = carry_reg;
    zero_next = zero_reg;
    save_hi_next = save_hi_reg;
    dest_next = dest_reg;
    hold_next = hold_reg;
    iret_next = iret_reg;
    rd_next = rd_reg;
    rd_valid_next = 1'b0;
    swap_next = swap_reg;
    case (state_reg)
      ST_IDLE: begin
        if (take) begin
          case (cmd_code)
            CMD_NOP: pc_next = pc_step1;
            CMD_PAGE: pc_next = pc_page;
            CMD_JUMP: pc_next = cmd_target;
            CMD_CALL, CMD_INT_ACK: begin
              pstk_next = pstk_reg + 8'h01;
              save_hi_next = {carry_reg, zero_reg, save_pc[13:8]};
              if (cmd_code == CMD_INT_ACK) begin
                ie_next = 1'b0;
                dest_next = cps_vector(int_source);
              end else begin
                dest_next = cmd_target;
              end
              state_next = ST_SAVE2;
            end
            CMD_SUB_RET, CMD_INT_RET: begin
              pstk_next = pstk_reg - 8'h01;
              iret_next = (cmd_code == CMD_INT_RET);
              state_next = ST_REST_HI;
            end
            CMD_LOAD_PSTK: begin
              pstk_next = acc_in;
              pc_next = pc_step1;
            end
            CMD_EI: begin
              ie_next = 1'b1;
              pc_next = pc_step1;
            end
            CMD_DI: begin
              ie_next = 1'b0;
              pc_next = pc_step1;
            end
            CMD_PUSH: begin
              dsp_next = dsp_dec;
              pc_next = pc_step1;
            end
            CMD_POP: begin
              rd_next = mem_bus.rdata;
              rd_valid_next = 1'b1;
              dsp_next = dsp_reg + 8'h01;
              pc_next = pc_step1;
            end
            CMD_SWAP_DSP: begin
              dsp_next = acc_in;
              swap_next = dsp_reg;
              pc_next = pc_step1;
            end
            CMD_LOAD_IMM: begin
              rd_next = cmd_operand;
              rd_valid_next = 1'b1;
              pc_next = pc_step2;
            end
            CMD_LOAD_DIR, CMD_LOAD_IDX: begin
              rd_next = mem_bus.rdata;
              rd_valid_next = 1'b1;
              pc_next = pc_step2;
            end
            CMD_STORE_DIR, CMD_STORE_IDX: pc_next = pc_step2;
            default: pc_next = pc_reg;
          endcase
        end else if (flag_we) begin
          carry_next = carry_in;
          zero_next = zero_in;
        end
      end
      ST_SAVE2: begin
        pstk_next = pstk_reg + 8'h01;
        pc_next = dest_reg;
        state_next = ST_IDLE;
      end
      ST_REST_HI: begin
        hold_next = mem_bus.rdata;
        pstk_next = pstk_reg - 8'h01;
        state_next = ST_REST_LO;
      end
      ST_REST_LO: begin
        pc_next = {hold_reg[5:0], mem_bus.rdata};
        if (iret_reg) begin
          carry_next = hold_reg[7];
          zero_next = hold_reg[6];
          ie_next = 1'b1;
        end
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  assign ready_next = (state_next == ST_IDLE);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_reg <= ST_IDLE;
      pc_reg <= PC_RESET;
      pstk_reg <= PSTK_RESET;
      dsp_reg <= DSP_RESET;
      ie_reg <= 1'b0;
      ready_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      pstk_reg <= pstk_next;
      dsp_reg <= dsp_next;
      ie_reg <= ie_next;
      ready_reg <= ready_next;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      carry_reg <= 1'b0;
      zero_reg <= 1'b0;
      rd_reg <= 8'h00;
      rd_valid_reg <= 1'b0;
      swap_reg <= 8'h00;
      rom_over_reg <= 1'b0;
    end else begin
      carry_reg <= carry_next;
      zero_reg <= zero_next;
      rd_reg <= rd_next;
      rd_valid_reg <= rd_valid_next;
      swap_reg <= swap_next;
      rom_over_reg <= (pc_next > USER_ROM_END);
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      save_hi_reg <= 8'h00;
      dest_reg <= PC_RESET;
      hold_reg <= 8'h00;
      iret_reg <= 1'b0;
    end else begin
      save_hi_reg <= save_hi_next;
      dest_reg <= dest_next;
      hold_reg <= hold_next;
      iret_reg <= iret_next;
    end
  end

  assign cmd_ready = ready_reg;
  assign pc = pc_reg;
  assign carry_flag = carry_reg;
  assign zero_flag = zero_reg;
  assign int_enable = ie_reg;
  assign read_data = rd_reg;
  assign read_valid = rd_valid_reg;
  assign swap_data = swap_reg;
  assign user_rom_over = rom_over_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_reset_clears_state: assert property (@(posedge sys_clk)
    srst |=> (pc_reg == PC_RESET) && (pstk_reg == PSTK_RESET) && (dsp_reg == DSP_RESET))
    else $error("reset did not clear counter or stack pointers");

  chk_low_byte_step: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_NOP) |=>
      (pc_reg[13:8] == $past(pc_reg[13:8])) && (pc_reg[7:0] == $past(pc_reg[7:0]) + 8'h01))
    else $error("sequential step touched upper counter bits");

  chk_page_advance: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_PAGE) |=> pc_reg[13:8] == $past(pc_reg[13:8]) + 6'h01)
    else $error("page advance did not bump upper bits");

  chk_int_push_seq: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_INT_ACK) |=>
      !ie_reg && (pstk_reg == $past(pstk_reg) + 8'h01) ##1
      (pstk_reg == $past(pstk_reg, 2) + 8'h02) && (pc_reg == cps_vector($past(int_source, 2))))
    else $error("interrupt acknowledge sequence wrong");

  chk_call_push_two: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_CALL) |=> ##1
      (pstk_reg == $past(pstk_reg, 2) + 8'h02) && (pc_reg == $past(cmd_target, 2)))
    else $error("call did not push two bytes and jump");

  chk_iret_restore: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_INT_RET) |=> !ie_reg [*2] ##1
      ie_reg && (pstk_reg == $past(pstk_reg, 3) - 8'h02))
    else $error("interrupt return pointer or enable wrong");

  chk_return_keeps_flags: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_SUB_RET) |=> ##2
      (carry_reg == $past(carry_reg, 3)) && (zero_reg == $past(zero_reg, 3)) &&
      (pstk_reg == $past(pstk_reg, 3) - 8'h02))
    else $error("plain return changed flags or pointer");

  chk_push_predec: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_PUSH) |-> mem_bus.we && (mem_bus.addr == dsp_reg - 8'h01))
    else $error("push did not write below the data pointer");

  chk_pop_postinc: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_POP) |=>
      read_valid && (read_data == $past(mem_bus.rdata)) && (dsp_reg == $past(dsp_reg) + 8'h01))
    else $error("pop read or increment wrong");

  chk_swap_exchange: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_SWAP_DSP) |=>
      (dsp_reg == $past(acc_in)) && (swap_data == $past(dsp_reg)))
    else $error("swap did not exchange values");

  chk_index_address: assert property (@(posedge sys_clk) disable iff (srst)
    take && (cmd_code == CMD_LOAD_IDX) |-> mem_bus.addr == 8'(cmd_operand + index_in))
    else $error("indexed address not base plus index");

endmodule // cps_core
`default_nettype wire

/* sim/cps_core_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module cps_core_tb_top
  import cps_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals and instance
  // ----------------------------------------------------------------
  logic sys_clk = 1'b0;
  logic srst = 1'b0;
  logic cmd_valid = 1'b0;
  cps_cmd_t cmd_code = CMD_NOP;
  logic [7:0] cmd_operand = 8'h00;
  logic [13:0] cmd_target = 14'h0000;
  cps_src_t int_source = SRC_BUS_RESET;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] index_in = 8'h00;
  logic flag_we = 1'b0;
  logic carry_in = 1'b0;
  logic zero_in = 1'b0;
  logic cmd_ready;
  logic [13:0] pc;
  logic carry_flag;
  logic zero_flag;
  logic int_enable;
  logic [7:0] read_data;
  logic read_valid;
  logic [7:0] swap_data;
  logic user_rom_over;
  int mismatches = 0;
  int comparisons = 0;

  cps_core cps_core_inst (
    .sys_clk(sys_clk), .srst(srst), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_operand(cmd_operand), .cmd_target(cmd_target), .int_source(int_source),
    .acc_in(acc_in), .index_in(index_in), .flag_we(flag_we), .carry_in(carry_in),
    .zero_in(zero_in), .cmd_ready(cmd_ready), .pc(pc), .carry_flag(carry_flag),
    .zero_flag(zero_flag), .int_enable(int_enable), .read_data(read_data),
    .read_valid(read_valid), .swap_data(swap_data), .user_rom_over(user_rom_over)
  );

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic do_reset();
    @(negedge sys_clk);
    srst = 1'b1;
    repeat (4) @(negedge sys_clk);
    srst = 1'b0;
    check(16'(pc), 16'h0000, "reset pc");
    check({15'h0000, cmd_ready}, 16'h0001, "reset ready");
    check({14'h0000, carry_flag, zero_flag}, 16'h0000, "reset flags");
    check({14'h0000, int_enable, read_valid}, 16'h0000, "reset enable");
    check({7'h00, user_rom_over, read_data}, 16'h0000, "reset read");
    check(16'(swap_data), 16'h0000, "reset swap");
  endtask

  task automatic wait_ready();
    int n;
    for (n = 0; n < 20 && cmd_ready !== 1'b1; n++) @(negedge sys_clk);
  endtask

  task automatic do_cmd(input cps_cmd_t c, input logic [7:0] op, input logic [13:0] tg);
    @(negedge sys_clk);
    wait_ready();
    cmd_code = c;
    cmd_operand = op;
    cmd_target = tg;
    cmd_valid = 1'b1;
    @(negedge sys_clk);
    cmd_valid = 1'b0;
  endtask

  task automatic read_cmd(input cps_cmd_t c, input logic [7:0] op, input logic [7:0] exp);
    do_cmd(c, op, 14'h0000);
    check({15'h0000, read_valid}, 16'h0001, "read pulse");
    check(16'(read_data), 16'(exp), "read data");
  endtask

  task automatic set_flags(input logic c, input logic z);
    @(negedge sys_clk);
    carry_in = c;
    zero_in = z;
    flag_we = 1'b1;
    @(negedge sys_clk);
    flag_we = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_pc_paging();
    do_reset();
    do_cmd(CMD_NOP, 8'h00, 14'h0000);
    check(16'(pc), 16'h0001, "seq step");
    do_cmd(CMD_JUMP, 8'h00, 14'h01FF);
    do_cmd(CMD_NOP, 8'h00, 14'h0000);
    check(16'(pc), 16'h0100, "low byte wrap");
    do_cmd(CMD_JUMP, 8'h00, 14'h01FF);
    do_cmd(CMD_PAGE, 8'h00, 14'h0000);
    check(16'(pc), 16'h0200, "page advance");
    do_cmd(CMD_JUMP, 8'h00, 14'h1FDF);
    check({15'h0000, user_rom_over}, 16'h0000, "rom end");
    do_cmd(CMD_JUMP, 8'h00, 14'h1FE0);
    check({15'h0000, user_rom_over}, 16'h0001, "test area");
    $display("test_pc_paging done");
  endtask

  task automatic test_vectors();
    logic [13:0] vtab [11] = '{14'h0002, 14'h0004, 14'h0006, 14'h0008, 14'h000A,
      14'h000C, 14'h000E, 14'h0010, 14'h0014, 14'h0016, 14'h0018};
    do_reset();
    for (int i = 0; i < 11; i++) begin
      do_cmd(CMD_JUMP, 8'h00, 14'h0140);
      do_cmd(CMD_EI, 8'h00, 14'h0000);
      check({15'h0000, int_enable}, 16'h0001, "ei");
      int_source = cps_src_t'(i);
      do_cmd(CMD_INT_ACK, 8'h00, 14'h0000);
      wait_ready();
      check(16'(pc), 16'(vtab[i]), "vector");
      check({15'h0000, int_enable}, 16'h0000, "ack disables");
      do_cmd(CMD_INT_RET, 8'h00, 14'h0000);
      wait_ready();
      check(16'(pc), 16'h0141, "iret pc");
      check({15'h0000, int_enable}, 16'h0001, "iret enables");
    end
    do_cmd(CMD_DI, 8'h00, 14'h0000);
    check({15'h0000, int_enable}, 16'h0000, "di");
    $display("test_vectors done");
  endtask

  task automatic test_call_ret();
    do_reset();
    set_flags(1'b1, 1'b0);
    do_cmd(CMD_JUMP, 8'h00, 14'h0120);
    do_cmd(CMD_CALL, 8'h00, 14'h0300);
    wait_ready();
    check(16'(pc), 16'h0300, "call dest");
    read_cmd(CMD_LOAD_DIR, 8'h00, 8'h22);
    read_cmd(CMD_LOAD_DIR, 8'h01, 8'h81);
    set_flags(1'b0, 1'b1);
    do_cmd(CMD_SUB_RET, 8'h00, 14'h0000);
    wait_ready();
    check(16'(pc), 16'h0122, "return pc");
    check({14'h0000, carry_flag, zero_flag}, 16'h0001, "return keeps flags");
    do_cmd(CMD_CALL, 8'h00, 14'h0310);
    wait_ready();
    read_cmd(CMD_LOAD_DIR, 8'h00, 8'h24);
    read_cmd(CMD_LOAD_DIR, 8'h01, 8'h41);
    do_cmd(CMD_INT_ACK, 8'h00, 14'h0000);
    wait_ready();
    read_cmd(CMD_LOAD_DIR, 8'h02, 8'h14);
    read_cmd(CMD_LOAD_DIR, 8'h03, 8'h43);
    set_flags(1'b1, 1'b1);
    do_cmd(CMD_INT_RET, 8'h00, 14'h0000);
    wait_ready();
    check(16'(pc), 16'h0314, "iret pc");
    check({14'h0000, carry_flag, zero_flag}, 16'h0001, "iret flags");
    do_cmd(CMD_SUB_RET, 8'h00, 14'h0000);
    wait_ready();
    check(16'(pc), 16'h0124, "nested return");
    acc_in = 8'h40;
    do_cmd(CMD_LOAD_PSTK, 8'h00, 14'h0000);
    do_cmd(CMD_JUMP, 8'h00, 14'h0150);
    do_cmd(CMD_CALL, 8'h00, 14'h0300);
    wait_ready();
    read_cmd(CMD_LOAD_DIR, 8'h40, 8'h52);
    read_cmd(CMD_LOAD_DIR, 8'h41, 8'h41);
    $display("test_call_ret done");
  endtask

  task automatic test_data_stack();
    do_reset();
    acc_in = 8'h5A;
    do_cmd(CMD_STORE_DIR, 8'h00, 14'h0000);
    acc_in = 8'hA5;
    do_cmd(CMD_PUSH, 8'h00, 14'h0000);
    check(16'(pc), 16'h0003, "push step");
    read_cmd(CMD_LOAD_DIR, 8'hFF, 8'hA5);
    read_cmd(CMD_LOAD_DIR, 8'h00, 8'h5A);
    acc_in = 8'h80;
    do_cmd(CMD_SWAP_DSP, 8'h00, 14'h0000);
    check(16'(swap_data), 16'h00FF, "dsp after push");
    acc_in = 8'h33;
    do_cmd(CMD_PUSH, 8'h00, 14'h0000);
    read_cmd(CMD_LOAD_DIR, 8'h7F, 8'h33);
    read_cmd(CMD_POP, 8'h00, 8'h33);
    acc_in = 8'h10;
    do_cmd(CMD_SWAP_DSP, 8'h00, 14'h0000);
    check(16'(swap_data), 16'h0080, "dsp after pop");
    $display("test_data_stack done");
  endtask

  task automatic test_modes();
    do_reset();
    do_cmd(CMD_JUMP, 8'h00, 14'h02FF);
    read_cmd(CMD_LOAD_IMM, 8'hD8, 8'hD8);
    check(16'(pc), 16'h0201, "two byte step");
    acc_in = 8'hC3;
    index_in = 8'h03;
    do_cmd(CMD_STORE_IDX, 8'h10, 14'h0000);
    read_cmd(CMD_LOAD_DIR, 8'h13, 8'hC3);
    acc_in = 8'h3C;
    index_in = 8'h20;
    do_cmd(CMD_STORE_IDX, 8'hF0, 14'h0000);
    read_cmd(CMD_LOAD_DIR, 8'h10, 8'h3C);
    index_in = 8'h03;
    read_cmd(CMD_LOAD_IDX, 8'h10, 8'hC3);
    acc_in = 8'h99;
    do_cmd(CMD_STORE_DIR, 8'h13, 14'h0000);
    read_cmd(CMD_LOAD_DIR, 8'h13, 8'h99);
    $display("test_modes done");
  endtask

  // ----------------------------------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    test_pc_paging();
    test_vectors();
    test_call_ret();
    test_data_stack();
    test_modes();
    finish_test();
  end

  initial begin
    #100000;
    mismatches++;
    $display("MISMATCH at %0t: watchdog expired", $time);
    finish_test();
  end

endmodule // cps_core_tb_top
`default_nettype wire
